// File: inc/fault_reg_map.vh
// Register map, field positions, reset values and timing for the serial register block
`ifndef FAULT_REG_MAP_VH
`define FAULT_REG_MAP_VH
`define FRAME_BITS        32
`define BIT_RW            31
`define ADDR_HI           30
`define ADDR_LO           24
`define ADDR_IDENT        7'h00
`define ADDR_CONFIG       7'h01
`define ADDR_FAULT        7'h02
`define IDENT_MFR_HI      23
`define IDENT_MFR_LO      16
`define IDENT_REV_HI      15
`define IDENT_REV_LO      8
`define IDENT_WDT_BIT     1
`define CFG_PROBE_HI      15
`define CFG_PROBE_LO      13
`define CFG_SLEW_HI       12
`define CFG_SLEW_LO       7
`define CFG_ENMASK_BIT    6
`define CFG_CHMASK_HI     5
`define CFG_CHMASK_LO     3
`define CFG_SIDE_HI       2
`define CFG_SIDE_LO       0
`define FLT_MEM_BIT       23
`define FLT_RST_BIT       22
`define FLT_PUMP_SD_BIT   21
`define FLT_PUMP_WARN_BIT 20
`define FLT_OVB_BIT       19
`define FLT_LOOP_HI       17
`define FLT_LOOP_LO       15
`define FLT_UV_HI         14
`define FLT_UV_LO         12
`define FLT_OT_HI         11
`define FLT_OT_LO         9
`define FLT_OLI_HI        8
`define FLT_OLI_LO        6
`define FLT_OLSB_HI       5
`define FLT_OLSB_LO       3
`define FLT_OVC_HI        2
`define FLT_OVC_LO        0
`define SLEW_RESERVED     2'h3
`define CFG_RESET         32'h01000000
`define FAULT_RESET       32'h02500000
`define LOOP_PERIODS      4'h8
`endif

// File: hw/pin_sync.v
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/100ps
module pin_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// File: hw/loop_err_det.v
// Per-channel regulation watchdog: flags when out of range for 8 modulation periods
`timescale 1ns/100ps
`include "fault_reg_map.vh"
module loop_err_det (
  input  wire clk,
  input  wire rst_n,
  input  wire period_tick,
  input  wire out_of_range,
  output reg  loop_err
);
  reg [3:0] cnt;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt      <= 4'h0;
      loop_err <= 1'b0;
    end else if (!out_of_range) begin
      cnt      <= 4'h0;
      loop_err <= 1'b0;
    end else if (period_tick) begin
      if (cnt != `LOOP_PERIODS)
        cnt <= cnt + 4'h1;
      loop_err <= (cnt + 4'h1 >= `LOOP_PERIODS);
    end
  end
endmodule

// File: hw/fault_spi_regs.v
// Serial slave with identity, configuration and fault status registers
// Operation
// [RQ1] Read returns addressed register next frame
// [RQ2] Read data ignored, no register change
// [RQ3] Write stores data into writable fields
// [RQ4] Reply after write shows real contents
// [RQ5] 32-bit frames, most significant bit first
// [RQ6] Invalid frame answered with identity register
// [RQ7] First frame after reset returns identity
// [RQ8] Reply bit 31 zero; read-only writes ignored
// [RQ9] Identity holds maker and revision codes
// [RQ10] Watchdog timeout bit sticky until reset
// [RQ11] Bits 15:13 select probe current side
// [RQ12] Slew selector code 11 keeps old setting
// [RQ13] Enable mask pulls fault low on enable-low
// [RQ14] Channel masks gate faults onto fault output
// [RQ15] Bits 2:0 mirror side strap pins
// [RQ16] Fault bits for memory, pump and battery
// [RQ17] Reset bit set on reset, cleared on read
// [RQ18] Regulation error after 8 modulation periods
// [RQ19] Per-channel supply, temp, load, current faults
// [RQ20] Memory and regulation bits clear on read
// [RQ21] Frames not exactly 32 bits discarded
// [RQ22] Sample on falling, shift on rising clock
// [RQ23] Bits 30:24 carry register address
`timescale 1ns/100ps
`include "fault_reg_map.vh"
module fault_spi_regs #(
  parameter [7:0] MFR_CODE = 8'h5A, // Arbitrary value
  parameter [7:0] REV_CODE = 8'h01  // Arbitrary value
) (
  input  wire       CLK,
  input  wire       RST_N,
  input  wire       SCK,
  input  wire       CS_N,
  input  wire       SDI,
  output reg        SDO,
  output reg        SDO_OE,
  input  wire       ENABLE_PIN,
  input  wire [2:0] SIDE_SELECT_STRAP,
  input  wire       CLOCK_WATCHDOG_TIMEOUT,
  input  wire       MEM_CHECK_FAULT,
  input  wire       PUMP_UV_SHUTDOWN,
  input  wire       PUMP_UV_WARNING,
  input  wire       BATTERY_OVERVOLTAGE,
  input  wire       PWM_PERIOD_TICK,
  input  wire [2:0] CURRENT_OUT_OF_RANGE,
  input  wire [2:0] LOAD_SUPPLY_UNDERVOLTAGE,
  input  wire [2:0] OVERTEMP_FAULT,
  input  wire [2:0] OPEN_LOAD_IDLE,
  input  wire [2:0] OPEN_LOAD_SWITCH_BYPASS,
  input  wire [2:0] OVERCURRENT_FAULT,
  output reg  [2:0] OFFSTATE_PROBE_CURRENT_SELECT,
  output reg  [5:0] SLEW_RATE_SELECT,
  output reg        FAULT_OUT_N
);
  wire       sck_s;
  wire       cs_n_s;
  wire       sdi_s;
  wire       en_s;
  wire [2:0] strap_s;
  wire       wdt_s;
  wire       mem_s;
  wire       pump_sd_s;
  wire       pump_warn_s;
  wire       ovb_s;
  wire       tick_s;
  wire [2:0] oor_s;
  wire [2:0] uv_s;
  wire [2:0] ot_s;
  wire [2:0] oli_s;
  wire [2:0] olsb_s;
  wire [2:0] ovc_s;
  wire [2:0] loop_err;

  // Every input except CLK and RST_N is synchronised before use, at the cost of two clocks of latency
  pin_sync #(.W(31)) u_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .d     ({SCK, CS_N, SDI, ENABLE_PIN, SIDE_SELECT_STRAP, CLOCK_WATCHDOG_TIMEOUT,
             MEM_CHECK_FAULT, PUMP_UV_SHUTDOWN, PUMP_UV_WARNING, BATTERY_OVERVOLTAGE,
             PWM_PERIOD_TICK, CURRENT_OUT_OF_RANGE, LOAD_SUPPLY_UNDERVOLTAGE,
             OVERTEMP_FAULT, OPEN_LOAD_IDLE, OPEN_LOAD_SWITCH_BYPASS, OVERCURRENT_FAULT}),
    .q     ({sck_s, cs_n_s, sdi_s, en_s, strap_s, wdt_s, mem_s, pump_sd_s, pump_warn_s,
             ovb_s, tick_s, oor_s, uv_s, ot_s, oli_s, olsb_s, ovc_s})
  );

  reg        sck_d;
  reg        cs_d;
  reg        tick_d;
  reg [31:0] shift_in;
  reg [31:0] shift_out;
  reg [5:0]  bit_cnt;
  reg [6:0]  last_addr;
  reg        last_valid;
  reg        wdt_flag;
  reg [2:0]  probe_sel;
  reg [5:0]  slew_sel;
  reg        en_mask;
  reg [2:0]  ch_mask;
  reg [2:0]  side_status;
  reg        mem_flag;
  reg        rst_flag;
  reg [2:0]  loop_flag;
  reg        next_mem_flag;
  reg        next_rst_flag;
  reg [2:0]  next_loop_flag;
  reg [2:0]  chan_fault;
  reg        next_fault_n;

  // Modulation periods are counted on the rising edge of the synced tick
  wire tick_rise = tick_s & ~tick_d;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_loop
      loop_err_det u_det (
        .clk          (CLK),
        .rst_n        (RST_N),
        .period_tick  (tick_rise),
        .out_of_range (oor_s[g]),
        .loop_err     (loop_err[g])
      );
    end
  endgenerate

  wire sck_fall   = sck_d & ~sck_s;
  wire sck_rise   = ~sck_d & sck_s;
  wire cs_fall    = cs_d & ~cs_n_s;
  wire cs_rise    = ~cs_d & cs_n_s;
  wire frame_ok   = cs_rise && (bit_cnt == `FRAME_BITS); // RQ21
  wire is_write   = shift_in[`BIT_RW];
  wire [6:0] addr = shift_in[`ADDR_HI:`ADDR_LO]; // RQ23
  wire addr_known = (addr == `ADDR_IDENT) || (addr == `ADDR_CONFIG) || (addr == `ADDR_FAULT);
  wire fault_read = cs_fall && last_valid && (last_addr == `ADDR_FAULT);

  // Replace code 11 by the previous setting, per channel
  function [5:0] slew_merge;
    input [5:0] cur;
    input [5:0] req;
    integer i;
    begin
      slew_merge = cur;
      for (i = 0; i < 3; i = i + 1)
        if (req[2*i +: 2] != `SLEW_RESERVED)
          slew_merge[2*i +: 2] = req[2*i +: 2]; // RQ12
    end
  endfunction

  // Register contents as they stand now
  function [31:0] reg_value;
    input [6:0] a;
    begin
      reg_value = 32'h00000000; // RQ8
      case (a)
        `ADDR_IDENT: begin
          reg_value[`IDENT_MFR_HI:`IDENT_MFR_LO] = MFR_CODE; // RQ9
          reg_value[`IDENT_REV_HI:`IDENT_REV_LO] = REV_CODE; // RQ9
          reg_value[`IDENT_WDT_BIT]              = wdt_flag; // RQ10
        end
        `ADDR_CONFIG: begin
          reg_value[`ADDR_HI:`ADDR_LO]           = `ADDR_CONFIG;
          reg_value[`CFG_PROBE_HI:`CFG_PROBE_LO] = probe_sel;
          reg_value[`CFG_SLEW_HI:`CFG_SLEW_LO]   = slew_sel;
          reg_value[`CFG_ENMASK_BIT]             = en_mask;
          reg_value[`CFG_CHMASK_HI:`CFG_CHMASK_LO] = ch_mask;
          reg_value[`CFG_SIDE_HI:`CFG_SIDE_LO]   = side_status; // RQ15
        end
        `ADDR_FAULT: begin
          reg_value[`ADDR_HI:`ADDR_LO]     = `ADDR_FAULT;
          reg_value[`FLT_MEM_BIT]          = mem_flag; // RQ16
          reg_value[`FLT_RST_BIT]          = rst_flag; // RQ17
          reg_value[`FLT_PUMP_SD_BIT]      = pump_sd_s; // RQ16
          reg_value[`FLT_PUMP_WARN_BIT]    = pump_warn_s; // RQ16
          reg_value[`FLT_OVB_BIT]          = ovb_s; // RQ16
          reg_value[`FLT_LOOP_HI:`FLT_LOOP_LO] = loop_flag; // RQ18
          reg_value[`FLT_UV_HI:`FLT_UV_LO] = uv_s; // RQ19
          reg_value[`FLT_OT_HI:`FLT_OT_LO] = ot_s; // RQ19
          reg_value[`FLT_OLI_HI:`FLT_OLI_LO] = oli_s; // RQ19
          reg_value[`FLT_OLSB_HI:`FLT_OLSB_LO] = olsb_s; // RQ19
          reg_value[`FLT_OVC_HI:`FLT_OVC_LO] = ovc_s; // RQ19
        end
        default: reg_value = 32'h00000000;
      endcase
    end
  endfunction

  // Read-clear takes effect once the reply is loaded; events in that cycle win
  always @* begin
    next_mem_flag  = mem_flag | mem_s; // RQ16
    next_loop_flag = loop_flag | loop_err; // RQ18
    next_rst_flag  = rst_flag;
    if (fault_read) begin
      next_mem_flag  = mem_s; // RQ20
      next_loop_flag = loop_err; // RQ20
      next_rst_flag  = 1'b0; // RQ17
    end
  end

  // Masked fault sources that pull the fault pin low
  always @* begin
    chan_fault   = loop_flag | uv_s | ot_s | oli_s | olsb_s | ovc_s;
    next_fault_n = 1'b1;
    if (en_mask && !en_s)
      next_fault_n = 1'b0; // RQ13
    if (|(ch_mask & chan_fault))
      next_fault_n = 1'b0; // RQ14
  end

  // Serial engine
  // Edges are found on synced copies, so the link clock must stay well below CLK
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sck_d      <= 1'b0;
      cs_d       <= 1'b1;
      tick_d     <= 1'b0;
      shift_in   <= 32'h00000000;
      shift_out  <= 32'h00000000;
      bit_cnt    <= 6'h00;
      last_addr  <= `ADDR_IDENT;
      last_valid <= 1'b0; // RQ7
      SDO        <= 1'b0;
      SDO_OE     <= 1'b0;
    end else begin
      sck_d  <= sck_s;
      cs_d   <= cs_n_s;
      tick_d <= tick_s;
      if (cs_fall) begin
        // Invalid or first frame after reset answers with identity
        shift_out <= reg_value(last_valid ? last_addr : `ADDR_IDENT); // RQ1 RQ4 RQ6 RQ7
        SDO       <= 1'b0; // RQ8
        SDO_OE    <= 1'b1;
        bit_cnt   <= 6'h00;
      end else if (!cs_n_s) begin
        if (sck_fall) begin
          shift_in <= {shift_in[30:0], sdi_s}; // RQ5 RQ22
          if (bit_cnt != 6'h3F)
            bit_cnt <= bit_cnt + 6'h01;
        end
        if (sck_rise) begin
          SDO       <= shift_out[30]; // RQ5 RQ22
          shift_out <= {shift_out[30:0], 1'b0};
        end
      end
      if (cs_rise) begin
        SDO_OE     <= 1'b0;
        SDO        <= 1'b0;
        last_valid <= frame_ok && addr_known; // RQ6 RQ21
        if (frame_ok && addr_known)
          last_addr <= addr; // RQ1
      end
    end
  end

  // Register file
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      probe_sel   <= 3'h0;
      slew_sel    <= 6'h00;
      en_mask     <= 1'b0;
      ch_mask     <= 3'h0;
      side_status <= 3'h0;
      wdt_flag    <= 1'b0;
      mem_flag    <= 1'b0;
      rst_flag    <= 1'b1; // RQ17
      loop_flag   <= 3'h0;
    end else begin
      // Straps are mirrored continuously, so the value follows the pins after reset
      side_status <= strap_s; // RQ15
      if (wdt_s)
        wdt_flag <= 1'b1; // RQ10
      // Writes only to configuration; other addresses behave as reads
      if (frame_ok && is_write && addr == `ADDR_CONFIG) begin // RQ2 RQ3 RQ8
        probe_sel <= shift_in[`CFG_PROBE_HI:`CFG_PROBE_LO]; // RQ11
        slew_sel  <= slew_merge(slew_sel, shift_in[`CFG_SLEW_HI:`CFG_SLEW_LO]); // RQ12
        en_mask   <= shift_in[`CFG_ENMASK_BIT];
        ch_mask   <= shift_in[`CFG_CHMASK_HI:`CFG_CHMASK_LO];
      end
      rst_flag  <= next_rst_flag; // RQ17
      mem_flag  <= next_mem_flag; // RQ16 RQ20
      loop_flag <= next_loop_flag; // RQ18 RQ20
    end
  end

  // Fault pin and configuration outputs
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      FAULT_OUT_N                   <= 1'b1;
      OFFSTATE_PROBE_CURRENT_SELECT <= 3'h0;
      SLEW_RATE_SELECT              <= 6'h00;
    end else begin
      OFFSTATE_PROBE_CURRENT_SELECT <= probe_sel; // RQ11
      SLEW_RATE_SELECT              <= slew_sel;
      FAULT_OUT_N                   <= next_fault_n; // RQ13 RQ14
    end
  end
endmodule

// File: dv/spi_host.sv
// Serial master model that sends one frame and collects the reply
`timescale 1ns/100ps
module spi_host (
  output logic sck,
  output logic cs_n,
  output logic sdi,
  input  wire  sdo
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // Reply bit is taken just before the clock rise that shifts the next one out
  task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
    r = '0;
    cs_n = 1'b0;
    #300;
    for (int i = 0; i < n; i++) begin
      r = {r[30:0], sdo};
      sck = 1'b1;
      sdi = w[31-i];
      #80;
      sck = 1'b0;
      #80;
    end
    #220;
    cs_n = 1'b1;
    sdi = ~sdi;
    #200;
  endtask
endmodule

// File: dv/fault_spi_regs_assertions.sv
// Pin-level checks for the serial register block
`timescale 1ns/100ps
module fault_spi_regs_assertions (
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic       SCK,
  input wire logic       CS_N,
  input wire logic       SDO,
  input wire logic       SDO_OE,
  input wire logic [2:0] OFFSTATE_PROBE_CURRENT_SELECT,
  input wire logic [5:0] SLEW_RATE_SELECT,
  input wire logic       FAULT_OUT_N
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_oe_on: assert property ($fell(CS_N) |-> ##[2:4] SDO_OE)
    else $error("output enable late");
  a_oe_off: assert property ($rose(CS_N) |-> ##[2:4] !SDO_OE)
    else $error("output enable stuck");
  a_oe_idle: assert property (CS_N [*6] |-> !SDO_OE)
    else $error("output enabled outside frame");
  a_lead_zero: assert property ($rose(SDO_OE) |-> !SDO)
    else $error("first reply bit not zero");
  a_sdo_shift: assert property (SDO_OE && $past(SDO_OE) && $changed(SDO)
    |-> $past(SCK, 2) || $past(SCK, 3) || $past(SCK, 4) || $past(SCK, 5))
    else $error("serial output moved without clock rise");
  a_cfg_quiet: assert property ($changed(SLEW_RATE_SELECT)
    || $changed(OFFSTATE_PROBE_CURRENT_SELECT) |-> CS_N)
    else $error("configuration changed inside frame");
  a_slew_legal: assert property (SLEW_RATE_SELECT[1:0] != 2'h3
    && SLEW_RATE_SELECT[3:2] != 2'h3 && SLEW_RATE_SELECT[5:4] != 2'h3)
    else $error("reserved slew code applied");
  a_fault_rst: assert property ($rose(RST_N) |-> FAULT_OUT_N [*3])
    else $error("fault output low after reset");
endmodule
bind fault_spi_regs fault_spi_regs_assertions chk (
  .CLK(CLK),
  .RST_N(RST_N),
  .SCK(SCK),
  .CS_N(CS_N),
  .SDO(SDO),
  .SDO_OE(SDO_OE),
  .OFFSTATE_PROBE_CURRENT_SELECT(OFFSTATE_PROBE_CURRENT_SELECT),
  .SLEW_RATE_SELECT(SLEW_RATE_SELECT),
  .FAULT_OUT_N(FAULT_OUT_N)
);

// File: dv/tb.sv
// Self-checking bench for the serial register block
`timescale 1ns/100ps
module tb;
  localparam logic [31:0] ID = 32'h003C0700;
  localparam logic [31:0] CF1 = 32'h0100D0DD;
  logic clk = 1'b0, rst_n = 1'b0, en = 1'b1, wdt = 1'b0, mem = 1'b0;
  logic psd = 1'b0, battery_overvoltage = 1'b0, tick = 1'b0;
  logic [2:0] oor = 3'h0, uv = 3'h0, ot = 3'h0, oli = 3'h0, olsb = 3'h0, ovc = 3'h0;
  logic sck, cs_n, sdi, sdo, oe, fault_n;
  logic [2:0] probe;
  logic [5:0] slew;
  logic [31:0] r;
  int fail_count = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  spi_host host (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
  // Identity codes below are arbitrary
  fault_spi_regs #(.MFR_CODE(8'h3C), .REV_CODE(8'h07)) dut (
    .CLK(clk), .RST_N(rst_n), .SCK(sck), .CS_N(cs_n), .SDI(sdi), .SDO(sdo),
    .SDO_OE(oe), .ENABLE_PIN(en), .SIDE_SELECT_STRAP(3'h5),
    .CLOCK_WATCHDOG_TIMEOUT(wdt), .MEM_CHECK_FAULT(mem), .PUMP_UV_SHUTDOWN(psd),
    .PUMP_UV_WARNING(1'b1), .BATTERY_OVERVOLTAGE(battery_overvoltage), .PWM_PERIOD_TICK(tick),
    .CURRENT_OUT_OF_RANGE(oor), .LOAD_SUPPLY_UNDERVOLTAGE(uv), .OVERTEMP_FAULT(ot),
    .OPEN_LOAD_IDLE(oli), .OPEN_LOAD_SWITCH_BYPASS(olsb), .OVERCURRENT_FAULT(ovc),
    .OFFSTATE_PROBE_CURRENT_SELECT(probe), .SLEW_RATE_SELECT(slew),
    .FAULT_OUT_N(fault_n)
  );
  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task fr(input logic [31:0] w, input int n, input logic [31:0] e);
    host.xfer(w, n, r);
    chk(r, e);
  endtask
  task wf(input logic e);
    int k;
    k = 0;
    while (fault_n !== e && k < 20) begin
      @(posedge clk);
      k++;
    end
    chk({31'h0, fault_n}, {31'h0, e});
    if (k == 20)
      conclude();
  endtask
  task t_reset;
    fr(32'h01000000, 32, ID);
    fr(32'h02000000, 32, 32'h01000005);
    fr(32'h00000000, 32, 32'h02500000);
    fr(32'h02000000, 32, ID);
    fr(32'h00000000, 32, 32'h02100000);
  endtask
  task t_write;
    fr(32'h8100D6DA, 32, ID);
    fr(32'h01FFFFFF, 32, CF1);
    chk({29'h0, probe}, 32'h6);
    chk({26'h0, slew}, 32'h21);
    fr(32'h80000000, 32, CF1);
    @(posedge clk);
    en <= 1'b0;
    wf(1'b0);
    en <= 1'b1;
    wf(1'b1);
    ovc <= 3'h4;
    repeat (8) @(posedge clk);
    chk({31'h0, fault_n}, 32'h1);
    ovc <= 3'h1;
    wf(1'b0);
    ovc <= 3'h0;
    wf(1'b1);
  endtask
  task t_invalid;
    fr(32'h81000000, 16, ID >> 16);
    fr(32'h05000000, 32, ID);
    fr(32'h01000000, 32, ID);
    fr(32'h82FFFFFF, 32, CF1);
    fr(32'h00000000, 32, 32'h02100000);
  endtask
  task t_faults;
    @(posedge clk);
    {wdt, mem, psd, battery_overvoltage} <= 4'hF;
    {uv, ot, oli, olsb, oor} <= 15'o12412;
    @(posedge clk);
    {wdt, mem} <= 2'h0;
    repeat (8) begin
      @(posedge clk);
      tick <= 1'b1;
      repeat (3) @(posedge clk);
      tick <= 1'b0;
      repeat (3) @(posedge clk);
    end
    oor <= 3'h0;
    fr(32'h02000000, 32, ID | 32'h2);
    fr(32'h00000000, 32, 32'h02B91508);
    fr(32'h02000000, 32, ID | 32'h2);
    fr(32'h00000000, 32, 32'h02381508);
  endtask
  task t_rereset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk({29'h0, probe}, 32'h0);
    fr(32'h02000000, 32, ID);
    fr(32'h00000000, 32, 32'h02781508);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    t_reset();
    t_write();
    t_invalid();
    t_faults();
    t_rereset();
    conclude();
  end
endmodule
